// ==== core/ctp_phase.v ====
// one complementary output pair with dead time and stop/trip handling
// assumes counters move together with the first ahead by the dead time
`timescale 1ns/1ps
`default_nettype none
module ctp_phase #(
    parameter W = 16
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire [W-1:0] cnt0_in,
    input wire [W-1:0] cnt1_in,
    input wire [W-1:0] cmp_in,
    input wire run_in,
    input wire stop_sel_in,
    input wire tripped_in,
    input wire nlvl_in,
    input wire clvl_in,
    output reg nor_out,
    output reg cnt_out
);
    wire nor_act;
    wire cnt_act;
    wire overlap;

    // second counter wrapped at the trough must not look like a high count
    assign nor_act = (cnt1_in > cmp_in) & ~(&cnt1_in);
    // first counter leads by the dead time, so the gap comes for free
    assign cnt_act = (cnt0_in <= cmp_in); // RQ13
    assign overlap = nor_act & cnt_act;

    // initial level is the select bit, active level its inverse
    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            nor_out <= 1'b0;
            cnt_out <= 1'b0;
        end
        else if (tripped_in) // RQ16
        begin
            nor_out <= nlvl_in; // RQ4
            cnt_out <= clvl_in;
        end
        else if (!run_in)
        begin
            if (stop_sel_in)
            begin
                nor_out <= nlvl_in; // RQ15
                cnt_out <= clvl_in; // RQ15
            end
        end
        else
        begin
            // overlap check is a last guard against odd software values
            nor_out <= (nor_act & ~overlap) ? ~nlvl_in : nlvl_in; // RQ17
            cnt_out <= (cnt_act & ~overlap) ? ~clvl_in : clvl_in; // RQ7
        end
    end
endmodule // ctp_phase
`default_nettype wire

// ==== core/ctp_top.v ====
// complementary three-phase pwm timer with apb register access
// assumes inputs synchronous to CORE_CLK_IN; oscillator arrives as an enable pulse
`include "ctp_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module ctp_top #(
    parameter W = 16
) (
    input wire CORE_CLK_IN,
    input wire RST_N_IN,
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [7:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    output reg [31:0] PRDATA_OUT,
    output reg PREADY_OUT,
    output reg PSLVERR_OUT,
    input wire HS_SOURCE_SELECT_IN,
    input wire HOCO_TICK_IN,
    input wire EXT_CLK_IN,
    input wire TRIP_IN,
    output reg [4:0] EVT_OUT,
    output reg HALF_PERIOD_TOGGLE_OUT,
    output wire PHASE1_NORMAL_OUT,
    output wire PHASE1_COUNTER_OUT,
    output wire PHASE2_NORMAL_OUT,
    output wire PHASE2_COUNTER_OUT,
    output wire PHASE3_NORMAL_OUT,
    output wire PHASE3_COUNTER_OUT
);
    reg [2:0] start_q;
    reg [9:0] fcr_q;
    reg [4:0] stat_q;
    reg trip_en_q;
    reg tripped_q;
    reg hs_sel_q;
    reg strap_done_q;
    reg down_q;
    reg [W-1:0] cnt0_q;
    reg [W-1:0] cnt1_q;
    reg [W-1:0] per_q;
    reg [W-1:0] cb0_q;
    reg [W-1:0] ca1_q;
    reg [W-1:0] cb1_q;
    reg [W-1:0] bb0_q;
    reg [W-1:0] ba1_q;
    reg [W-1:0] bb1_q;
    reg [4:0] div_q;
    reg ext_q;
    reg ext_prev_q;
    reg tick;
    reg [31:0] rdata;
    reg hit;
    wire acc;
    wire wr;
    wire run;
    wire [2:0] cks;
    wire [1:0] buf_mode;
    wire crest;
    wire trough;
    wire [4:0] ev;
    wire xfer;

    assign acc = PSEL_IN & PENABLE_IN & PREADY_OUT;
    assign wr = acc & PWRITE_IN;
    assign run = start_q[`CTP_START_RUN0] & start_q[`CTP_START_RUN1]; // RQ14
    assign cks = fcr_q[`CTP_FCR_CKS_MSB:`CTP_FCR_CKS_LSB];
    assign buf_mode = fcr_q[`CTP_FCR_BUF_MSB:`CTP_FCR_BUF_LSB];

    // high-speed source bit caught once after reset release, like an option byte
    always @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            hs_sel_q <= 1'b0;
            strap_done_q <= 1'b0;
        end
        else if (!strap_done_q)
        begin
            hs_sel_q <= HS_SOURCE_SELECT_IN; // RQ11
            strap_done_q <= 1'b1;
        end
    end

    // prescaler and external pin sampling
    always @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            div_q <= 5'h00;
            ext_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end
        else
        begin
            div_q <= div_q + 5'h01;
            ext_q <= EXT_CLK_IN;
            ext_prev_q <= ext_q;
        end
    end

    // count enable; external pin overrides only when its enable bit is set
    always @*
    begin
        tick = 1'b0;
        if (fcr_q[`CTP_FCR_EXTCLK])
            tick = ext_q & ~ext_prev_q; // RQ10
        else
        begin
            case (cks)
                `CTP_CKS_HS: tick = hs_sel_q ? HOCO_TICK_IN : 1'b1; // RQ11
                `CTP_CKS_DIV1: tick = 1'b1;
                `CTP_CKS_DIV2: tick = (div_q[0] == 1'b1);
                `CTP_CKS_DIV4: tick = (div_q[1:0] == 2'h3);
                `CTP_CKS_DIV8: tick = (div_q[2:0] == 3'h7);
                `CTP_CKS_DIV32: tick = (div_q == 5'h1f);
                default: tick = 1'b1;
            endcase
        end
    end

    // crest at the period match going up, trough at the wrap going down
    assign crest = run & tick & ~down_q & (cnt0_q == per_q);
    assign trough = run & tick & down_q & (cnt1_q == `CTP_RST_CNT);
    assign ev[`CTP_EV_PER] = crest; // RQ1
    assign ev[`CTP_EV_B0] = run & tick & (cnt0_q == cb0_q); // RQ1
    assign ev[`CTP_EV_A1] = run & tick & (cnt1_q == ca1_q); // RQ1
    assign ev[`CTP_EV_B1] = run & tick & (cnt1_q == cb1_q); // RQ1
    assign ev[`CTP_EV_UDF] = trough; // RQ1

    // buffered compares move in at the chosen turning point
    assign xfer = (buf_mode == `CTP_BUF_CREST & crest) |
        (buf_mode == `CTP_BUF_TROUGH & trough) |
        (buf_mode == `CTP_BUF_BOTH & (crest | trough)); // RQ8

    // up/down counters; a software write wins over counting
    always @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            cnt0_q <= `CTP_RST_CNT;
            cnt1_q <= `CTP_RST_CNT;
            down_q <= 1'b0;
        end
        else
        begin
            if (wr && PADDR_IN == `CTP_REG_CNT0)
                cnt0_q <= PWDATA_IN[W-1:0]; // RQ3
            else if (run && tick)
                cnt0_q <= down_q ? cnt0_q - 1'b1 : cnt0_q + 1'b1; // RQ12
            if (wr && PADDR_IN == `CTP_REG_CNT1)
                cnt1_q <= PWDATA_IN[W-1:0]; // RQ3
            else if (run && tick)
                cnt1_q <= down_q ? cnt1_q - 1'b1 : cnt1_q + 1'b1; // RQ12
            if (crest)
                down_q <= 1'b1; // RQ12
            else if (trough)
                down_q <= 1'b0; // RQ12
        end
    end

    // event pulses for the event link unit and half-period toggle
    always @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            EVT_OUT <= 5'h00;
            HALF_PERIOD_TOGGLE_OUT <= 1'b0;
        end
        else
        begin
            EVT_OUT <= ev; // RQ9
            if (tripped_q || (!run && start_q[`CTP_START_STOPSEL]))
                HALF_PERIOD_TOGGLE_OUT <= fcr_q[`CTP_FCR_NLVL]; // RQ15
            else if (crest || trough)
                HALF_PERIOD_TOGGLE_OUT <= ~HALF_PERIOD_TOGGLE_OUT; // RQ5
        end
    end

    // trip latch: stays set until software clears it, new trip wins
    always @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
            tripped_q <= 1'b0;
        else if (trip_en_q && TRIP_IN)
            tripped_q <= 1'b1; // RQ4
        else if (wr && PADDR_IN == `CTP_REG_TRIP && PWDATA_IN[`CTP_TRIP_HIT])
            tripped_q <= 1'b0; // RQ16
    end

    // software registers; status flags clear by writing one, set wins
    always @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            start_q <= 3'h0;
            fcr_q <= `CTP_RST_FCR;
            stat_q <= 5'h00;
            trip_en_q <= 1'b0;
            per_q <= `CTP_RST_CMP;
            cb0_q <= `CTP_RST_CMP;
            ca1_q <= `CTP_RST_CMP;
            cb1_q <= `CTP_RST_CMP;
            bb0_q <= `CTP_RST_CMP;
            ba1_q <= `CTP_RST_CMP;
            bb1_q <= `CTP_RST_CMP;
        end
        else
        begin
            if (wr && PADDR_IN == `CTP_REG_STAT)
                stat_q <= (stat_q & ~PWDATA_IN[4:0]) | ev; // RQ1
            else
                stat_q <= stat_q | ev; // RQ1
            if (wr)
            begin
                case (PADDR_IN)
                    `CTP_REG_START: start_q <= PWDATA_IN[2:0];
                    `CTP_REG_FCR: fcr_q <= PWDATA_IN[9:0];
                    `CTP_REG_TRIP: trip_en_q <= PWDATA_IN[`CTP_TRIP_EN];
                    `CTP_REG_PER: per_q <= PWDATA_IN[W-1:0];
                    `CTP_REG_CB0: bb0_q <= PWDATA_IN[W-1:0];
                    `CTP_REG_CA1: ba1_q <= PWDATA_IN[W-1:0];
                    `CTP_REG_CB1: bb1_q <= PWDATA_IN[W-1:0];
                    default: start_q <= start_q;
                endcase
            end
            // without buffering the written value goes live one cycle after the write
            if (buf_mode == `CTP_BUF_NONE || xfer)
            begin
                cb0_q <= bb0_q; // RQ8
                ca1_q <= ba1_q;
                cb1_q <= bb1_q;
            end
        end
    end

    // read mux; unmapped addresses answer zero with an error
    always @*
    begin
        rdata = 32'h0000_0000;
        hit = 1'b1;
        case (PADDR_IN)
            `CTP_REG_START: rdata[2:0] = start_q;
            `CTP_REG_FCR: rdata[9:0] = fcr_q;
            `CTP_REG_STAT: rdata[5:0] = {down_q, stat_q};
            `CTP_REG_TRIP: rdata[1:0] = {tripped_q, trip_en_q};
            `CTP_REG_CNT0: rdata[W-1:0] = cnt0_q; // RQ2
            `CTP_REG_CNT1: rdata[W-1:0] = cnt1_q; // RQ2
            `CTP_REG_PER: rdata[W-1:0] = per_q;
            `CTP_REG_CB0: rdata[W-1:0] = bb0_q;
            `CTP_REG_CA1: rdata[W-1:0] = ba1_q;
            `CTP_REG_CB1: rdata[W-1:0] = bb1_q;
            default: hit = 1'b0;
        endcase
    end

    // one wait state keeps the read data a clean flop output
    always @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            PREADY_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
            PSLVERR_OUT <= 1'b0;
        end
        else
        begin
            PREADY_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT;
            if (PSEL_IN && PENABLE_IN && !PREADY_OUT)
            begin
                PRDATA_OUT <= PWRITE_IN ? 32'h0000_0000 : rdata;
                PSLVERR_OUT <= ~hit;
            end
            else
                PSLVERR_OUT <= 1'b0;
        end
    end

    // phase 1 on channel 0 b/d, phase 2 on channel 1 a/c, phase 3 on b/d
    ctp_phase #(.W(W)) u_ph1 (
        .clk_in(CORE_CLK_IN),
        .rst_n_in(RST_N_IN),
        .cnt0_in(cnt0_q),
        .cnt1_in(cnt1_q),
        .cmp_in(cb0_q),
        .run_in(run),
        .stop_sel_in(start_q[`CTP_START_STOPSEL]),
        .tripped_in(tripped_q),
        .nlvl_in(fcr_q[`CTP_FCR_NLVL]),
        .clvl_in(fcr_q[`CTP_FCR_CLVL]),
        .nor_out(PHASE1_NORMAL_OUT), // RQ6
        .cnt_out(PHASE1_COUNTER_OUT)
    );
    ctp_phase #(.W(W)) u_ph2 (
        .clk_in(CORE_CLK_IN),
        .rst_n_in(RST_N_IN),
        .cnt0_in(cnt0_q),
        .cnt1_in(cnt1_q),
        .cmp_in(ca1_q),
        .run_in(run),
        .stop_sel_in(start_q[`CTP_START_STOPSEL]),
        .tripped_in(tripped_q),
        .nlvl_in(fcr_q[`CTP_FCR_NLVL]),
        .clvl_in(fcr_q[`CTP_FCR_CLVL]),
        .nor_out(PHASE2_NORMAL_OUT), // RQ6
        .cnt_out(PHASE2_COUNTER_OUT)
    );
    ctp_phase #(.W(W)) u_ph3 (
        .clk_in(CORE_CLK_IN),
        .rst_n_in(RST_N_IN),
        .cnt0_in(cnt0_q),
        .cnt1_in(cnt1_q),
        .cmp_in(cb1_q),
        .run_in(run),
        .stop_sel_in(start_q[`CTP_START_STOPSEL]),
        .tripped_in(tripped_q),
        .nlvl_in(fcr_q[`CTP_FCR_NLVL]),
        .clvl_in(fcr_q[`CTP_FCR_CLVL]),
        .nor_out(PHASE3_NORMAL_OUT), // RQ6
        .cnt_out(PHASE3_COUNTER_OUT)
    );
endmodule // ctp_top
`default_nettype wire

// ==== shared/ctp_consts.vh ====
// constants of the complementary three-phase pwm block
// assumes a 32-bit apb slave with byte addresses on word boundaries
// Operation
// [RQ1] requests on compare match and second-counter underflow
// [RQ2] software reads either counter any time
// [RQ3] software writes load a counter
// [RQ4] external trigger input disables pwm outputs
// [RQ5] toggle output inverts every half period
// [RQ6] three phases routed to fixed output pairs
// [RQ7] separate levels for normal and counter phases
// [RQ8] software picks buffer-to-compare transfer timing
// [RQ9] timer events offered to event link unit
// [RQ10] external clock counts only when enabled
// [RQ11] option bit picks system clock or oscillator
// [RQ12] up to period match, down to wrap
// [RQ13] dead time is first counter start value
// [RQ14] software starts by setting both run bits
// [RQ15] stopped with stop select: initial levels out
// [RQ16] trip holds outputs off until software re-enables
// [RQ17] never both outputs of a pair active
`ifndef CTP_CONSTS_VH
`define CTP_CONSTS_VH

// register byte offsets
`define CTP_REG_START 8'h00
`define CTP_REG_FCR 8'h04
`define CTP_REG_STAT 8'h08
`define CTP_REG_TRIP 8'h0c
`define CTP_REG_CNT0 8'h10
`define CTP_REG_CNT1 8'h14
`define CTP_REG_PER 8'h18
`define CTP_REG_CB0 8'h1c
`define CTP_REG_CA1 8'h20
`define CTP_REG_CB1 8'h24

// start_reg fields
`define CTP_START_RUN0 0
`define CTP_START_RUN1 1
`define CTP_START_STOPSEL 2

// function_control_reg fields
`define CTP_FCR_NLVL 0
`define CTP_FCR_CLVL 1
`define CTP_FCR_EXTCLK 2
`define CTP_FCR_CKS_LSB 4
`define CTP_FCR_CKS_MSB 6
`define CTP_FCR_BUF_LSB 8
`define CTP_FCR_BUF_MSB 9

// count source codes
`define CTP_CKS_HS 3'h0
`define CTP_CKS_DIV1 3'h1
`define CTP_CKS_DIV2 3'h2
`define CTP_CKS_DIV4 3'h3
`define CTP_CKS_DIV8 3'h4
`define CTP_CKS_DIV32 3'h5

// buffer transfer timing codes
`define CTP_BUF_NONE 2'h0
`define CTP_BUF_CREST 2'h1
`define CTP_BUF_TROUGH 2'h2
`define CTP_BUF_BOTH 2'h3

// status flag positions, also event vector positions except the direction bit
`define CTP_EV_PER 0
`define CTP_EV_B0 1
`define CTP_EV_A1 2
`define CTP_EV_B1 3
`define CTP_EV_UDF 4
`define CTP_STAT_DOWN 5

// trip register fields
`define CTP_TRIP_EN 0
`define CTP_TRIP_HIT 1

// reset values
`define CTP_RST_FCR 10'h000
`define CTP_RST_CMP 16'hffff
`define CTP_RST_CNT 16'h0000
`define CTP_CNT_WRAP 16'hffff

// option byte holding the high-speed source select bit
`define CTP_OPT_BYTE_ADDR 20'h000c2

`endif

// ==== verification/ctp_checker_assertions.sv ====
// apb and event checks for the pwm block
// assumes binding onto ctp_top
`timescale 1ns/1ps
`default_nettype none
module ctp_checker #(
    parameter W = 16
) (
    input wire CORE_CLK_IN,
    input wire RST_N_IN,
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [7:0] PADDR_IN,
    input wire [31:0] PRDATA_OUT,
    input wire PREADY_OUT,
    input wire PSLVERR_OUT,
    input wire [4:0] EVT_OUT
);
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    // answer after exactly one wait state
    a_one_wait: assert property (PSEL_IN && !PENABLE_IN |=> !PREADY_OUT ##1 PREADY_OUT)
        else $error("ready not after one wait");
    a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held");
    a_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("error without ready");
    a_unmapped_err: assert property (PREADY_OUT && PADDR_IN > 8'h24 |->
        PSLVERR_OUT && PRDATA_OUT == 32'h0)
        else $error("unmapped not refused");
    a_mapped_ok: assert property (PREADY_OUT && PADDR_IN <= 8'h24 && PADDR_IN[1:0] == 2'h0 |->
        !PSLVERR_OUT)
        else $error("mapped refused");
    a_write_zero: assert property (PREADY_OUT && PWRITE_IN |-> PRDATA_OUT == 32'h0)
        else $error("write data nonzero");
    a_cnt_upper: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN >= 8'h10 |->
        PRDATA_OUT[31:W] == 0)
        else $error("upper bits set");
    a_udf_pulse: assert property (EVT_OUT[4] |=> !EVT_OUT[4])
        else $error("underflow held");
    a_crest_trough: assert property (!(EVT_OUT[0] && EVT_OUT[4]))
        else $error("crest with trough");
    c_err: cover property (PSLVERR_OUT);
    c_crest: cover property (EVT_OUT[0]);
    c_udf: cover property (EVT_OUT[4]);
endmodule // ctp_checker
bind ctp_top ctp_checker #(.W(W)) chk_u (.CORE_CLK_IN(CORE_CLK_IN), .RST_N_IN(RST_N_IN),
    .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .EVT_OUT(EVT_OUT));
`default_nettype wire

// ==== verification/ctp_switch_model.sv ====
// power switch pairs fed by the pwm pins
// assumes gate order p1n p1c p2n p2c p3n p3c
`timescale 1ns/1ps
`default_nettype none
module ctp_switch_model (
    input wire logic clk_in,
    input wire logic nlvl_in,
    input wire logic clvl_in,
    input wire logic [5:0] gate_in,
    output var logic [7:0] shoot_out
);
    initial shoot_out = 8'h0;
    // count cycles where a leg pair conducts together
    always @(posedge clk_in)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (gate_in[2*i+1] != nlvl_in && gate_in[2*i] != clvl_in)
                shoot_out <= shoot_out + 8'h1;
        end
    end
endmodule // ctp_switch_model
`default_nettype wire

// ==== verification/tb_ctp_top.sv ====
// self-checking bench for the pwm block
// assumes one wait state apb and the switch model
`timescale 1ns/1ps
`default_nettype none
module tb_ctp_top;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic psel = 1'h0;
    logic pen = 1'h0;
    logic pwr = 1'h0;
    logic [7:0] pa = 8'h0;
    logic [31:0] pwd = 32'h0;
    logic trip = 1'h0;
    logic ext = 1'h0;
    logic nl = 1'h0;
    logic tog_q = 1'h0;
    logic win = 1'h0;
    logic hs = 1'h0;
    logic hoco = 1'h0;
    logic err;
    logic [31:0] r;
    logic [31:0] a;
    wire [31:0] prd;
    wire rdy;
    wire serr;
    wire tog;
    wire [4:0] evt;
    wire [5:0] gate;
    wire [7:0] shoot;
    int fails = 0;
    int n_tests = 0;
    int cyc_n = 0;
    int tog_n = 0;
    int ev_n = 0;
    int dead_n = 0;
    initial forever #2.5 clk = ~clk;
    ctp_top #(.W(16)) dut_u (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd),
        .PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(serr),
        .HS_SOURCE_SELECT_IN(hs), .HOCO_TICK_IN(hoco), .EXT_CLK_IN(ext),
        .TRIP_IN(trip), .EVT_OUT(evt), .HALF_PERIOD_TOGGLE_OUT(tog),
        .PHASE1_NORMAL_OUT(gate[5]), .PHASE1_COUNTER_OUT(gate[4]),
        .PHASE2_NORMAL_OUT(gate[3]), .PHASE2_COUNTER_OUT(gate[2]),
        .PHASE3_NORMAL_OUT(gate[1]), .PHASE3_COUNTER_OUT(gate[0]));
    ctp_switch_model sw_u (.clk_in(clk), .nlvl_in(nl), .clvl_in(1'h0), .gate_in(gate),
        .shoot_out(shoot));
    // toggle and event tally, plus hang guard
    always @(posedge clk)
    begin
        cyc_n <= cyc_n + 1;
        tog_q <= tog;
        if (win)
        begin
            tog_n <= tog_n + (tog != tog_q);
            ev_n <= ev_n + evt[0] + evt[4];
            // both gates of pair 1 off: the dead-time gap
            dead_n <= dead_n + (gate[5:4] == 2'h0);
        end
        if (cyc_n == 5000)
        begin
            fails = fails + 1;
            results();
        end
    end
    // one apb transfer; waits for ready with no assumed latency
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        pa <= ad;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        @(posedge clk);
        while (rdy !== 1'h1)
            @(posedge clk);
        r = prd;
        err = serr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'h1, ad, d);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        apb(1'h0, ad, 32'h0);
        chk(r, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // main sequence
    initial
    begin
        idle(8);
        rst_n <= 1'h1;
        rd(8'h04, 32'h0);
        rd(8'h1c, 32'hffff);
        rd(8'h10, 32'h0);
        rd(8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h04, {22'h0, i[1:0], 8'h10});
            rd(8'h04, {22'h0, i[1:0], 8'h10});
        end
        wr(8'h10, 32'h2);
        rd(8'h10, 32'h2);
        wr(8'h14, 32'h0);
        wr(8'h18, 32'h8);
        wr(8'h1c, 32'h4);
        wr(8'h20, 32'h3);
        wr(8'h24, 32'h5);
        wr(8'h08, 32'h1f);
        wr(8'h04, 32'h10);
        wr(8'h00, 32'h3);
        idle(40);
        apb(1'h0, 8'h14, 32'h0);
        a = r;
        apb(1'h0, 8'h14, 32'h0);
        chk({31'h0, r !== a}, 32'h1);
        win <= 1'h1;
        idle(64);
        win <= 1'h0;
        idle(2);
        chk({31'h0, (tog_n - ev_n) * (tog_n - ev_n) <= 1}, 32'h1);
        chk({31'h0, ev_n >= 6}, 32'h1);
        // two gaps of 2 counts per 16-cycle period, four whole periods seen
        chk(dead_n, 32'h10);
        apb(1'h0, 8'h08, 32'h0);
        chk(r & 32'h1f, 32'h1f);
        // levels change only while outputs sit at initial level
        wr(8'h00, 32'h4);
        nl <= 1'h1;
        wr(8'h04, 32'h11);
        idle(4);
        chk({25'h0, gate, tog}, {25'h0, 6'h2a, 1'h1});
        wr(8'h0c, 32'h1);
        wr(8'h00, 32'h7);
        idle(20);
        trip <= 1'h1;
        idle(3);
        trip <= 1'h0;
        idle(10);
        chk({25'h0, gate, tog}, {25'h0, 6'h2a, 1'h1});
        rd(8'h0c, 32'h3);
        wr(8'h0c, 32'h3);
        idle(40);
        rd(8'h0c, 32'h1);
        chk({24'h0, shoot}, 32'h0);
        wr(8'h00, 32'h4);
        // reset with the timer stopped clears the direction and straps the oscillator source
        hs <= 1'h1;
        rst_n <= 1'h0;
        idle(2);
        rst_n <= 1'h1;
        rd(8'h08, 32'h0);
        wr(8'h10, 32'h0);
        wr(8'h14, 32'h0);
        nl <= 1'h0;
        wr(8'h04, 32'h4);
        wr(8'h00, 32'h3);
        idle(10);
        rd(8'h14, 32'h0);
        repeat (3)
        begin
            ext <= 1'h1;
            idle(3);
            ext <= 1'h0;
            idle(3);
        end
        idle(4);
        rd(8'h14, 32'h3);
        // oscillator ticks count; the pin is ignored once its enable drops
        wr(8'h04, 32'h0);
        repeat (2)
        begin
            hoco <= 1'h1;
            ext <= 1'h1;
            idle(1);
            hoco <= 1'h0;
            idle(3);
            ext <= 1'h0;
            idle(1);
        end
        rd(8'h14, 32'h5);
        results();
    end
endmodule // tb_ctp_top
`default_nettype wire
